/* hw/xcvr_pkg.sv */
// package: offsets, field layouts, reset values and carrier types of the transceiver
package xcvr_pkg;
	// register byte addresses
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_LOAD = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	// control register fields
	localparam int CTRL_SW_MODE = 0;
	localparam int CTRL_DRIVE_N = 1;
	localparam int CTRL_LATCH_EN = 2;
	localparam int CTRL_OE_N = 3;
	localparam int CTRL_DATA_LSB = 8;
	// status register fields
	localparam int STATUS_DRV_LSB = 0;
	localparam int STATUS_LATCH_LSB = 4;
	localparam int STATUS_BUS_LSB = 8;
	localparam int STATUS_PARITY = 12;
	localparam int STATUS_SW_MODE = 13;

	// the three mode controls that share one path
	typedef struct packed {
		logic drive_n;
		logic latch_en;
		logic oe_n;
	} ctl_t;

	// every asynchronous pin input, synchronised as one group
	typedef struct packed {
		logic clk_pin;
		ctl_t ctl;
		logic [3:0] data;
		logic [3:0] bus;
	} pins_t;

	// reset values: drivers and receiver outputs off
	localparam ctl_t CTL_RESET = '{drive_n: 1'b1, latch_en: 1'b0, oe_n: 1'b1};
	localparam pins_t PINS_RESET = '{clk_pin: 1'b0, ctl: CTL_RESET, data: 4'h0, bus: 4'h0};
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam logic [3:0] NIB_ALL = 4'hf;

	// odd parity output as the device defines it: xor of the four bits
	function automatic logic parity4(input logic [3:0] d);
		parity4 = ^d;
	endfunction
endpackage

/* hw/pin_sync3.sv */
// three-stage synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 import xcvr_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire pins_t raw,
	output pins_t stable
);
	typedef struct packed {
		pins_t s1;
		pins_t s2;
		pins_t s3;
		pins_t held;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// s1 feeds only s2; the agree filter looks at s2 and s3
	always_comb begin
		next_st = st;
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// agreeing stages load the new level, disagreeing stages keep the old one
		next_st.held = (st.s2 & st.s3) | (st.held & (st.s2 ^ st.s3));
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '{PINS_RESET, PINS_RESET, PINS_RESET, PINS_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign stable = st.held;
endmodule // pin_sync3
`default_nettype wire

/* hw/rx_latch.sv */
// receiver: inverting input, transparent-while-low latch, three-state outputs
`timescale 1ns/1ps
`default_nettype none
module rx_latch import xcvr_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] bus_level,
	input wire logic latch_en,
	input wire logic oe_n,
	output logic [3:0] q,
	output logic [3:0] next_q,
	output logic rx_oe_n
);
	typedef struct packed {
		logic [3:0] q;
		logic oe_n;
	} latch_state_t;

	latch_state_t st;
	latch_state_t next_st;

	// open latch follows the inverted bus, closed latch keeps its word
	always_comb begin
		next_st = st; // closed latch keeps its word
		if (!latch_en) begin
			next_st.q = ~bus_level;
		end
		next_st.oe_n = oe_n; // one common enable for all four outputs
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '{q: NIB_RESET, oe_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;
	assign next_q = next_st.q;
	assign rx_oe_n = st.oe_n;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_latch_open;
		!latch_en |=> q == ~$past(bus_level);
	endproperty
	a_latch_open: assert property (p_latch_open) else $error("open latch did not follow bus");

	property p_latch_hold;
		latch_en ##1 latch_en |-> $stable(q);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

	property p_oe_common;
		1'b1 |=> rx_oe_n == $past(oe_n);
	endproperty
	a_oe_common: assert property (p_oe_common) else $error("receiver enable not applied");
endmodule // rx_latch
`default_nettype wire

/* hw/quad_bus_transceiver_parity.sv */
// quad bus transceiver with driver register, receiver latch, odd parity and register port
// Summary of operation
// - each driver clock rising edge loads all four driver bits at once; in software mode only a write to OFS_LOAD loads them.
// - each bus line carries the inverse of its driver register bit.
// - receivers invert the bus, so data arrives non-inverted end to end.
// - receivers see the bus whether this device or another agent drives it.
// - drive enable high floats all four drivers; low makes them drive.
// - latch enable low makes the receiver latch transparent.
// - latch enable high closes the latch and holds the captured word.
// - one common enable switches all four receiver outputs together.
// - receiver enable high floats receiver outputs; low drives latched data.
// - drivers enabled: parity output is odd parity of driver inputs.
// - drivers floating: parity output is odd parity of latch outputs.
`timescale 1ns/1ps
`default_nettype none
module quad_bus_transceiver_parity import xcvr_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] driver_data,
	input wire logic driver_register_clock,
	input wire logic bus_drive_enable_n,
	input wire logic receiver_latch_enable,
	input wire logic receiver_output_enable_n,
	input wire logic [3:0] bus_in,
	output logic [3:0] bus_out,
	output logic [3:0] bus_oe_n,
	output logic [3:0] rx_out,
	output logic rx_oe_n,
	output logic parity_out
);
	typedef struct packed {
		logic sw_mode;
		ctl_t sw_ctl;
		logic [3:0] sw_data;
		logic ack;
		logic [31:0] rdata;
		logic clk_prev;
		logic [3:0] drv_q;
		logic [3:0] bus_out;
		logic [3:0] bus_oe_n;
		logic parity;
	} core_state_t;

	core_state_t st;
	core_state_t next_st;
	pins_t raw;
	pins_t pin;
	ctl_t ctl;
	logic [3:0] data_in;
	logic [3:0] latch_q;
	logic [3:0] latch_next;
	logic req;
	logic accept;
	logic load_sw;
	logic clk_rise;
	logic capture;

	// all pin inputs come from outside the clock domain
	assign raw = '{clk_pin: driver_register_clock,
		ctl: '{drive_n: bus_drive_enable_n, latch_en: receiver_latch_enable,
			oe_n: receiver_output_enable_n},
		data: driver_data, bus: bus_in};

	pin_sync3 u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.raw(raw),
		.stable(pin)
	);

	// software mode lets the register port stand in for the control pins
	assign ctl = st.sw_mode ? st.sw_ctl : pin.ctl;
	assign data_in = st.sw_mode ? st.sw_data : pin.data;

	// the bus level read back covers both our drive and any other agent
	rx_latch u_rx (
		.core_clk(core_clk),
		.rst(rst),
		.bus_level(pin.bus),
		.latch_en(ctl.latch_en),
		.oe_n(ctl.oe_n),
		.q(latch_q),
		.next_q(latch_next),
		.rx_oe_n(rx_oe_n)
	);

	// one wait state: the read word is registered before waitrequest drops
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~st.ack;
	assign accept = req & st.ack;
	assign load_sw = accept & avs_write & (avs_address == OFS_LOAD);
	assign clk_rise = pin.clk_pin & ~st.clk_prev;
	// pin clock is ignored in software mode to avoid double loads
	assign capture = st.sw_mode ? load_sw : clk_rise;

	// register port, driver register, bus drive and parity
	always_comb begin
		next_st = st;
		next_st.ack = req & ~st.ack;
		next_st.clk_prev = pin.clk_pin;
		if (req && !st.ack) begin
			next_st.rdata = 32'h0000_0000;
			if (avs_read && avs_address == OFS_CTRL) begin
				next_st.rdata[CTRL_SW_MODE] = st.sw_mode;
				next_st.rdata[CTRL_DRIVE_N] = st.sw_ctl.drive_n;
				next_st.rdata[CTRL_LATCH_EN] = st.sw_ctl.latch_en;
				next_st.rdata[CTRL_OE_N] = st.sw_ctl.oe_n;
				next_st.rdata[CTRL_DATA_LSB +: 4] = st.sw_data;
			end else if (avs_read && avs_address == OFS_STATUS) begin
				next_st.rdata[STATUS_DRV_LSB +: 4] = st.drv_q;
				next_st.rdata[STATUS_LATCH_LSB +: 4] = latch_q;
				next_st.rdata[STATUS_BUS_LSB +: 4] = pin.bus;
				next_st.rdata[STATUS_PARITY] = st.parity;
				next_st.rdata[STATUS_SW_MODE] = st.sw_mode;
			end
		end
		if (accept && avs_write && avs_address == OFS_CTRL) begin
			if (avs_byteenable[0]) begin
				next_st.sw_mode = avs_writedata[CTRL_SW_MODE];
				next_st.sw_ctl.drive_n = avs_writedata[CTRL_DRIVE_N];
				next_st.sw_ctl.latch_en = avs_writedata[CTRL_LATCH_EN];
				next_st.sw_ctl.oe_n = avs_writedata[CTRL_OE_N];
			end
			if (avs_byteenable[1]) begin
				next_st.sw_data = avs_writedata[CTRL_DATA_LSB +: 4];
			end
		end
		if (capture) begin
			next_st.drv_q = data_in; // all four bits in one edge
		end
		next_st.bus_out = ~next_st.drv_q;
		next_st.bus_oe_n = ctl.drive_n ? NIB_ALL : NIB_RESET;
		// parity mode follows the drive enable level
		if (ctl.drive_n) begin
			next_st.parity = parity4(latch_next); // check mode
		end else begin
			next_st.parity = parity4(data_in); // generate mode
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '{sw_mode: 1'b0, sw_ctl: CTL_RESET, sw_data: NIB_RESET, ack: 1'b0,
				rdata: 32'h0000_0000, clk_prev: 1'b0, drv_q: NIB_RESET,
				bus_out: NIB_ALL, bus_oe_n: NIB_ALL, parity: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata = st.rdata;
	assign bus_out = st.bus_out;
	assign bus_oe_n = st.bus_oe_n;
	assign rx_out = latch_q; // three-state data, qualified by rx_oe_n
	assign parity_out = st.parity;

	// checks on the transceiver paths
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_capture;
		capture |=> st.drv_q == $past(data_in);
	endproperty
	a_capture: assert property (p_capture) else $error("driver register missed a load");

	property p_no_capture;
		!capture |=> $stable(st.drv_q);
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("driver register changed without clock");

	property p_pin_edge;
		!st.sw_mode && pin.clk_pin && !st.clk_prev |=> st.drv_q == $past(pin.data);
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("pin clock edge did not load");

	property p_drive_inv;
		$changed(st.drv_q) |-> bus_out == ~st.drv_q;
	endproperty
	a_drive_inv: assert property (p_drive_inv) else $error("bus not inverse of register");

	property p_float;
		ctl.drive_n |=> bus_oe_n == NIB_ALL;
	endproperty
	a_float: assert property (p_float) else $error("drivers not floated");

	property p_drive_on;
		!ctl.drive_n |=> bus_oe_n == NIB_RESET;
	endproperty
	a_drive_on: assert property (p_drive_on) else $error("drivers not enabled");

	property p_rx_path;
		!ctl.latch_en |=> rx_out == ~$past(pin.bus);
	endproperty
	a_rx_path: assert property (p_rx_path) else $error("receiver path not inverting bus");

	property p_gen;
		!ctl.drive_n |=> parity_out == ^$past(data_in);
	endproperty
	a_gen: assert property (p_gen) else $error("generated parity wrong");

	property p_check;
		ctl.drive_n |=> parity_out == ^rx_out;
	endproperty
	a_check: assert property (p_check) else $error("checked parity wrong");

	property p_wait;
		req && !st.ack |-> avs_waitrequest ##1 (!req || !avs_waitrequest);
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest held too long");

	// receiver side: a closed latch freezes both the outputs and the checked parity
	property p_rx_hold;
		ctl.latch_en |=> $stable(rx_out);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("receiver outputs moved while closed");

	property p_check_hold;
		ctl.drive_n && ctl.latch_en && $past(ctl.drive_n) |=> $stable(parity_out);
	endproperty
	a_check_hold: assert property (p_check_hold) else $error("check parity moved on held data");

	// driver side: the four enables only ever switch as one group
	property p_oe_group;
		bus_oe_n == NIB_ALL || bus_oe_n == NIB_RESET;
	endproperty
	a_oe_group: assert property (p_oe_group) else $error("bus drivers split");

	property p_bus_steady;
		!capture |=> bus_out == ~$past(st.drv_q);
	endproperty
	a_bus_steady: assert property (p_bus_steady) else $error("bus not inverse of held register");

	// software mode: only the register port may load the driver register
	property p_sw_load;
		load_sw && st.sw_mode |=> st.drv_q == $past(st.sw_data);
	endproperty
	a_sw_load: assert property (p_sw_load) else $error("software load missed");

	property p_sw_pin_ignored;
		st.sw_mode && !load_sw |=> $stable(st.drv_q);
	endproperty
	a_sw_pin_ignored: assert property (p_sw_pin_ignored) else $error("pin clock loaded in software mode");

	// register port: one wait state, a one-cycle answer and a read word that stands
	property p_ack_pulse;
		st.ack |=> !st.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");

	property p_wait_first;
		$rose(req) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("request answered without wait state");

	property p_rdata_stands;
		!req |=> $stable(avs_readdata);
	endproperty
	a_rdata_stands: assert property (p_rdata_stands) else $error("read word changed while idle");

	property p_read_ctrl;
		accept && avs_read && avs_address == OFS_CTRL |-> avs_readdata[CTRL_DATA_LSB +: 4] == st.sw_data;
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("control readback wrong");

	property p_read_status_drv;
		accept && avs_read && avs_address == OFS_STATUS |-> avs_readdata[STATUS_DRV_LSB +: 4] == $past(st.drv_q);
	endproperty
	a_read_status_drv: assert property (p_read_status_drv) else $error("status register word wrong");

	property p_read_status_mode;
		accept && avs_read && avs_address == OFS_STATUS |-> avs_readdata[STATUS_SW_MODE] == st.sw_mode;
	endproperty
	a_read_status_mode: assert property (p_read_status_mode) else $error("status mode bit wrong");

	property p_read_unmapped;
		accept && avs_read && avs_address != OFS_CTRL && avs_address != OFS_STATUS |-> avs_readdata == 32'h0000_0000;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

	property p_write_mode;
		accept && avs_write && avs_address == OFS_CTRL && avs_byteenable[0]
			|=> st.sw_mode == $past(avs_writedata[CTRL_SW_MODE]);
	endproperty
	a_write_mode: assert property (p_write_mode) else $error("control write lost mode bit");

	property p_write_data;
		accept && avs_write && avs_address == OFS_CTRL && avs_byteenable[1]
			|=> st.sw_data == $past(avs_writedata[CTRL_DATA_LSB +: 4]);
	endproperty
	a_write_data: assert property (p_write_data) else $error("control write lost data field");


	c_pin_load: cover property (!st.sw_mode && clk_rise ##1 !ctl.drive_n);
	c_sw_load: cover property (load_sw);
	c_hold_check: cover property (ctl.latch_en && ctl.drive_n ##3 ctl.latch_en);
	c_status_read: cover property (accept && avs_read && avs_address == OFS_STATUS);
	c_latch_reopen: cover property (ctl.latch_en ##1 !ctl.latch_en);
endmodule // quad_bus_transceiver_parity
`default_nettype wire

/* verif/bus_agent.sv */
// partner model: the shared bus with one other agent and line resolution
`timescale 1ns/1ps
`default_nettype none
module bus_agent import xcvr_pkg::*; (
	input wire logic core_clk,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe_n,
	input wire logic agent_en,
	input wire logic [3:0] agent_val,
	output logic [3:0] bus_level
);
	// floating lines toggle every cycle so a stale value is never mistaken for data
	logic [3:0] float_pat = 4'h5;
	always_ff @(posedge core_clk) begin
		float_pat <= ~float_pat;
	end
	// the agent only drives while the device floats the line, so no contention
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!dev_oe_n[i]) begin
				bus_level[i] = dev_out[i];
			end else if (agent_en) begin
				bus_level[i] = agent_val[i];
			end else begin
				bus_level[i] = float_pat[i];
			end
		end
	end
endmodule // bus_agent
`default_nettype wire

/* verif/quad_bus_transceiver_parity_tb_top.sv */
// testbench: pin and register scenarios for the transceiver
`timescale 1ns/1ps
`default_nettype none
module quad_bus_transceiver_parity_tb_top import xcvr_pkg::*; ;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] driver_data = 4'h0;
	logic driver_register_clock = 1'b0;
	logic bus_drive_enable_n = 1'b1;
	logic receiver_latch_enable = 1'b0;
	logic receiver_output_enable_n = 1'b1;
	logic [3:0] bus_level, bus_out, bus_oe_n, rx_out;
	logic rx_oe_n, parity_out;
	logic agent_en = 1'b0;
	logic [3:0] agent_val = 4'h0;
	logic [31:0] rd;
	int err_count = 0;
	int tests_run = 0;

	always #12.5 core_clk = ~core_clk;

	quad_bus_transceiver_parity quad_bus_transceiver_parity_i (.core_clk(core_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .driver_data(driver_data),
		.driver_register_clock(driver_register_clock), .bus_drive_enable_n(bus_drive_enable_n),
		.receiver_latch_enable(receiver_latch_enable), .receiver_output_enable_n(receiver_output_enable_n),
		.bus_in(bus_level), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .rx_out(rx_out),
		.rx_oe_n(rx_oe_n), .parity_out(parity_out));
	bus_agent bus_agent_i (.core_clk(core_clk), .dev_out(bus_out), .dev_oe_n(bus_oe_n),
		.agent_en(agent_en), .agent_val(agent_val), .bus_level(bus_level));

	task automatic end_sim();
		$display("mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// one avalon transfer; entered just after a rising edge, leaves just after one
	task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
		logic w;
		int n;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= 4'h3;
		avs_read <= !wr;
		avs_write <= wr;
		w = 1'b1;
		n = 0;
		// taken at the rising edge itself, before that edge's register updates land
		while (w !== 1'b0 && n < 50) begin
			@(posedge core_clk);
			w = avs_waitrequest;
			d = avs_readdata;
			n++;
		end
		if (w !== 1'b0) begin
			err_count++;
			$display("CHECK FAILED %0t bus transfer never answered", $time);
			end_sim();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask

	// wait a bounded time for a pin output to reach its expected value
	task automatic chk(input int s, input logic [3:0] e);
		logic [3:0] g;
		for (int n = 0; n < 20; n++) begin
			@(negedge core_clk);
			case (s)
				0: g = bus_out;
				1: g = bus_oe_n;
				2: g = rx_out;
				3: g = {3'h0, rx_oe_n};
				default: g = {3'h0, parity_out};
			endcase
			if (g === e) break;
		end
		@(posedge core_clk);
		cmp({28'h0, g}, {28'h0, e});
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		cyc(1);
		chk(1, NIB_ALL);
		chk(3, 4'h1);
		bus_xfer(1'b0, OFS_CTRL, 32'h0, rd);
		cmp(rd, 32'h0000000a);
		// transmit from the pins, parity in generate mode
		bus_drive_enable_n <= 1'b0; // generate mode while transmitting
		chk(1, 4'h0);
		for (int v = 1; v < 16; v += 4) begin
			driver_data <= v[3:0];
			cyc(5);
			driver_register_clock <= 1'b1;
			cyc(5);
			driver_register_clock <= 1'b0;
			chk(0, ~v[3:0]);
			chk(2, v[3:0]);
			driver_data <= v[3:0] ^ 4'h2;
			chk(4, {3'h0, ^(v[3:0] ^ 4'h2)});
			chk(0, ~v[3:0]);
		end
		// receive from the other agent, parity in check mode
		bus_drive_enable_n <= 1'b1; // check mode while receiving
		chk(1, NIB_ALL);
		agent_en <= 1'b1;
		agent_val <= 4'h2;
		receiver_output_enable_n <= 1'b0;
		chk(2, 4'hd);
		chk(3, 4'h0);
		chk(4, 4'h1);
		receiver_latch_enable <= 1'b1;
		cyc(5);
		agent_val <= 4'h9;
		cyc(10);
		chk(2, 4'hd);
		receiver_latch_enable <= 1'b0;
		chk(2, 4'h6);
		chk(4, 4'h0);
		receiver_output_enable_n <= 1'b1;
		chk(3, 4'h1);
		agent_en <= 1'b0;
		// software mode: drive enabled, load 9 through the register port
		bus_xfer(1'b1, OFS_CTRL, 32'h00000901, rd);
		bus_xfer(1'b1, OFS_LOAD, 32'h0, rd);
		chk(0, 4'h6);
		bus_xfer(1'b0, OFS_STATUS, 32'h0, rd);
		cmp(rd & 32'h0000200f, 32'h00002009);
		// pin clock is ignored in software mode, so the register keeps its word
		driver_data <= 4'h0;
		driver_register_clock <= 1'b1;
		cyc(8);
		driver_register_clock <= 1'b0;
		cyc(8);
		chk(0, 4'h6);
		bus_xfer(1'b0, 4'hc, 32'h0, rd);
		cmp(rd, 32'h0);
		end_sim();
	end
endmodule // quad_bus_transceiver_parity_tb_top
`default_nettype wire
